// ===== core/osccs_top.sv
`timescale 1ns/100ps
module osccs_top
  import osccs_pkg::*;
#(
  parameter int POWER_UP_DELAY_TIMER_CYCLES   = POWER_UP_DELAY_TIMER_CYC,
  parameter int HF_START_CYC  = 64,
  parameter int MF_START_CYC  = 32,
  parameter int LF_START_CYC  = 16,
  parameter int HF_LOCK_CYC   = 128,
  parameter int HF_STABLE_CYC = 512
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        por_supply_ok,
  input  wire logic        sleep_req,
  input  wire logic        wake_req,
  input  wire logic        crystal_in_pin,
  input  wire logic        high_freq_internal_clock,
  input  wire logic        mid_freq_internal_clock,
  input  wire logic        low_freq_internal_clock,
  input  wire logic        internal_multiplier,
  input  wire logic        crystal_out_pin_in,
  output logic             crystal_out_pin_out,
  output logic             crystal_out_pin_oe_n,
  output logic             crystal_in_gpio,
  output logic             crystal_out_gpio,
  output logic             hf_osc_enable,
  output logic             mf_osc_enable,
  output logic             lf_osc_enable,
  output logic             multiplier_enable,
  output logic [5:0]       frequency_tuning,
  output logic             core_reset_n,
  output logic             core_run,
  output logic             sys_clock_out
);
  logic [7:0]  clock_control_reg;
  logic [5:0]  cfg_word;
  logic [5:0]  frequency_tuning_reg;
  logic [8:0]  clock_status_reg;
  osccs_boot_t boot;
  osccs_sw_t   sw;
  logic [22:0] power_up_delay_timer_cnt;
  logic [10:0] ost_cnt;
  logic        xtal_q;
  logic [8:0]  hf_div;
  logic [3:0]  mf_div;
  logic        hf_q;
  logic        mf_q;
  logic [9:0]  hf_cnt;
  logic [6:0]  mf_cnt;
  logic [6:0]  lf_cnt;
  logic        hf_ready;
  logic        mf_ready;
  logic        lf_ready;
  logic        hf_locked;
  logic        hf_stable;
  logic [2:0]  cur_src;
  logic [3:0]  cur_path;
  logic        cur_prev;
  logic        new_prev;
  logic [2:0]  tgt_src_q;
  logic [3:0]  tgt_path_q;
  logic [1:0]  instr_div;
  logic        sys_prev;

  // Source and divide exponent of each select code
  function automatic logic [2:0] path_src(input logic [3:0] code);
    if (code[3:1] == 3'h0)
      path_src = SRC_LF;
    else if (code == 4'h2 || code[3:2] == 2'h1)
      path_src = SRC_MF;
    else
      path_src = SRC_HF;
  endfunction

  function automatic logic [3:0] path_div(input logic [3:0] code);
    case (code)
      4'hF:    path_div = 4'h0;
      4'hE:    path_div = 4'h1;
      4'hD:    path_div = 4'h2;
      4'hC:    path_div = 4'h3;
      4'hB:    path_div = 4'h4;
      4'hA:    path_div = 4'h5;
      4'h9:    path_div = 4'h6;
      4'h8:    path_div = 4'h7;
      4'h3:    path_div = 4'h9;
      4'h7:    path_div = 4'h0;
      4'h6:    path_div = 4'h1;
      4'h5:    path_div = 4'h2;
      4'h4:    path_div = 4'h3;
      4'h2:    path_div = 4'h4;
      default: path_div = 4'h0;
    endcase
  endfunction

  // Level of the clock that a source and path produce
  function automatic logic path_level(input logic [2:0] src,
                                      input logic [3:0] code);
    logic [3:0] d;
    d = path_div(code);
    case (src)
      SRC_EXT:  path_level = crystal_in_pin;
      SRC_LF:   path_level = low_freq_internal_clock;
      SRC_MF:   path_level = (d == 4'h0) ? mid_freq_internal_clock
                                         : mf_div[d[1:0] - 2'h1];
      SRC_HF:   path_level = (d == 4'h0) ? high_freq_internal_clock
                                         : hf_div[d - 4'h1];
      SRC_MULT: path_level = internal_multiplier;
      default:  path_level = 1'b0;
    endcase
  endfunction

  function automatic logic src_ready(input logic [2:0] src,
                                     input logic hr, input logic mr,
                                     input logic lr);
    case (src)
      SRC_LF:  src_ready = lr;
      SRC_MF:  src_ready = mr;
      SRC_HF:  src_ready = hr;
      SRC_MULT: src_ready = hr;
      default: src_ready = 1'b1;
    endcase
  endfunction

  // Configuration and control decoding
  wire [1:0] scs       = clock_control_reg[CTRL_SCS_LSB +: 2];
  wire [3:0] ircf      = clock_control_reg[CTRL_IRCF_LSB +: 4];
  wire [2:0] fosc      = cfg_word[CFG_FOSC_LSB +: 3];
  wire       cfg_multiplier_enable = cfg_word[CFG_PLL_BIT];
  wire       sw_multiplier_enable  = clock_control_reg[CTRL_SWPLL_BIT];
  wire       clock_output_enable_n = cfg_word[CFG_INSTRUCTION_CLOCK_OUT_BIT];
  wire       power_up_delay_timer_enable_n         = cfg_word[CFG_POWER_UP_DELAY_TIMER_BIT];
  wire       mult_on   = cfg_multiplier_enable | sw_multiplier_enable;
  wire       internal_clock_mode = scs[1] | (fosc == FOSC_INT);
  wire       xtal_mode = !internal_clock_mode && (fosc < FOSC_EC);
  // Multiplier stays off for the internal block once scs is nonzero
  wire       mult_path = mult_on && (scs == 2'h0) && (fosc == FOSC_INT)
                         && (ircf == IRCF_MULT);
  wire [2:0] tgt_src   = !internal_clock_mode ? SRC_EXT :
                         mult_path ? SRC_MULT : path_src(ircf);
  wire [3:0] tgt_path  = ircf;
  wire       tgt_ready = src_ready(tgt_src_q, hf_ready, mf_ready, lf_ready);
  wire       cur_level = path_level(cur_src, cur_path);
  wire       new_level = path_level(tgt_src_q, tgt_path_q);
  wire       same_sel  = (tgt_src == cur_src) && (tgt_path == cur_path);
  wire       hf_edge   = high_freq_internal_clock & !hf_q;
  wire       mf_edge   = mid_freq_internal_clock & !mf_q;
  wire       xtal_edge = crystal_in_pin & !xtal_q;
  wire       use_hf    = cur_src == SRC_HF || tgt_src_q == SRC_HF ||
                         cur_src == SRC_MULT || tgt_src_q == SRC_MULT;
  // The high oscillator is built on the medium one, so it keeps it running
  wire       use_mf    = use_hf || cur_src == SRC_MF || tgt_src_q == SRC_MF;
  wire       use_lf    = cur_src == SRC_LF || tgt_src_q == SRC_LF;

  // Register bus decode
  wire        bus_req  = (avs_read | avs_write) & avs_waitrequest;
  wire        wr_go    = avs_write & !avs_waitrequest;
  wire        hit_ctrl = avs_address == ADDR_CTRL;
  wire        hit_cfg  = avs_address == ADDR_CFG;
  wire        hit_tune = avs_address == ADDR_TUNE;
  wire [31:0] rd_mux   =
    hit_ctrl ? {24'h000000, clock_control_reg} :
    (avs_address == ADDR_STATUS) ? {23'h000000, clock_status_reg} :
    hit_tune ? {26'h0000000, frequency_tuning_reg} :
    hit_cfg  ? {26'h0000000, cfg_word} : 32'h00000000;

  // One wait cycle per access; writes land at the edge waitrequest is low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      avs_waitrequest <= !bus_req;
      if (bus_req && avs_read)
        avs_readdata <= rd_mux;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clock_control_reg    <= CTRL_RST;
      cfg_word             <= CFG_RST;
      frequency_tuning_reg <= TUNE_RST;
    end else if (wr_go) begin
      if (hit_ctrl)
        clock_control_reg <= avs_writedata[7:0];
      if (hit_cfg)
        cfg_word <= avs_writedata[5:0];
      if (hit_tune)
        frequency_tuning_reg <= avs_writedata[TUNE_W-1:0];
    end
  end

  // Power-on, power-up delay and start-up count sequence
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      boot     <= OSCCS_POR;
      power_up_delay_timer_cnt <= 23'h000000;
      ost_cnt  <= 11'h000;
    end else if (!por_supply_ok) begin
      boot     <= OSCCS_POR;
      power_up_delay_timer_cnt <= 23'h000000;
      ost_cnt  <= 11'h000;
    end else begin
      case (boot)
        OSCCS_POR: begin
          boot     <= power_up_delay_timer_enable_n ? OSCCS_OST : OSCCS_POWER_UP_DELAY_TIMER;
          power_up_delay_timer_cnt <= 23'h000000;
          ost_cnt  <= 11'h000;
        end
        OSCCS_POWER_UP_DELAY_TIMER: begin
          power_up_delay_timer_cnt <= power_up_delay_timer_cnt + 23'h000001;
          if (power_up_delay_timer_cnt >= 23'(POWER_UP_DELAY_TIMER_CYCLES - 1))
            boot <= OSCCS_OST;
        end
        OSCCS_OST: begin
          if (!xtal_mode || ost_cnt == 11'(OST_EDGES))
            boot <= OSCCS_RUN;
          else if (xtal_edge)
            ost_cnt <= ost_cnt + 11'h001;
        end
        OSCCS_RUN: begin
          if (sleep_req)
            boot <= OSCCS_SLP;
        end
        OSCCS_SLP: begin
          if (wake_req) begin
            boot    <= OSCCS_OST;
            ost_cnt <= 11'h000;
          end
        end
        default: boot <= OSCCS_POR;
      endcase
    end
  end

  // Edge history and postscaler dividers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hf_q   <= 1'b0;
      mf_q   <= 1'b0;
      xtal_q <= 1'b0;
      hf_div <= 9'h000;
      mf_div <= 4'h0;
    end else begin
      hf_q   <= high_freq_internal_clock;
      mf_q   <= mid_freq_internal_clock;
      xtal_q <= crystal_in_pin;
      if (hf_edge)
        hf_div <= hf_div + 9'h001;
      if (mf_edge)
        mf_div <= mf_div + 4'h1;
    end
  end

  // Oscillator start-up, lock and stability timing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hf_cnt <= 10'h000;
      mf_cnt <= 7'h00;
      lf_cnt <= 7'h00;
    end else begin
      if (!hf_osc_enable)
        hf_cnt <= 10'h000;
      else if (hf_cnt != 10'(HF_STABLE_CYC))
        hf_cnt <= hf_cnt + 10'h001;
      if (!mf_osc_enable)
        mf_cnt <= 7'h00;
      else if (mf_cnt != 7'(MF_START_CYC))
        mf_cnt <= mf_cnt + 7'h01;
      if (!lf_osc_enable)
        lf_cnt <= 7'h00;
      else if (lf_cnt != 7'(LF_START_CYC))
        lf_cnt <= lf_cnt + 7'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hf_ready  <= 1'b0;
      mf_ready  <= 1'b0;
      lf_ready  <= 1'b0;
      hf_locked <= 1'b0;
      hf_stable <= 1'b0;
    end else begin
      hf_ready  <= hf_osc_enable && mf_ready
                   && hf_cnt >= 10'(HF_START_CYC);
      hf_locked <= hf_osc_enable && hf_cnt >= 10'(HF_LOCK_CYC);
      hf_stable <= hf_osc_enable && hf_cnt >= 10'(HF_STABLE_CYC);
      mf_ready  <= mf_osc_enable && mf_cnt >= 7'(MF_START_CYC);
      lf_ready  <= lf_osc_enable && lf_cnt >= 7'(LF_START_CYC);
    end
  end

  // Glitch-free switch between clock paths
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sw         <= OSCCS_IDLE;
      cur_src    <= SRC_EXT;
      cur_path   <= 4'h0;
      tgt_src_q  <= SRC_EXT;
      tgt_path_q <= 4'h0;
      cur_prev   <= 1'b0;
      new_prev   <= 1'b0;
    end else begin
      cur_prev <= cur_level;
      new_prev <= new_level;
      case (sw)
        OSCCS_IDLE: begin
          if (!same_sel) begin
            tgt_src_q  <= tgt_src;
            tgt_path_q <= tgt_path;
            sw         <= OSCCS_WAKE;
          end
        end
        OSCCS_WAKE: begin
          // Already running sources pass straight through
          if (tgt_ready)
            sw <= OSCCS_FALL;
        end
        OSCCS_FALL: begin
          if (cur_prev && !cur_level)
            sw <= OSCCS_HOLD;
        end
        OSCCS_HOLD: begin
          if (!new_prev && new_level) begin
            cur_src  <= tgt_src_q;
            cur_path <= tgt_path_q;
            sw       <= OSCCS_UPD;
          end
        end
        OSCCS_UPD: sw <= OSCCS_IDLE;
        default:   sw <= OSCCS_IDLE;
      endcase
    end
  end

  // Ready and start-up bits refresh only in idle or once the new clock is live; busy and pin bits every cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clock_status_reg <= 9'h000;
    end else begin
      clock_status_reg[ST_BUSY] <= sw != OSCCS_IDLE;
      clock_status_reg[ST_PIN]  <= crystal_out_pin_in;
      if (sw == OSCCS_IDLE || sw == OSCCS_UPD) begin
        clock_status_reg[ST_HF_READY]   <= hf_ready;
        clock_status_reg[ST_HF_LOCKED]  <= hf_locked;
        clock_status_reg[ST_HF_STABLE]  <= hf_stable;
        clock_status_reg[ST_MF_READY]   <= mf_ready;
        clock_status_reg[ST_LF_READY]   <= lf_ready;
        clock_status_reg[ST_MULT_READY] <= multiplier_enable & hf_ready;
        clock_status_reg[ST_OST_DONE]   <= boot == OSCCS_RUN;
      end
    end
  end

  // Output pins, enables and clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sys_clock_out        <= 1'b0;
      sys_prev             <= 1'b0;
      instr_div            <= 2'h0;
      crystal_out_pin_out  <= 1'b0;
      crystal_out_pin_oe_n <= 1'b1;
      crystal_in_gpio      <= 1'b0;
      crystal_out_gpio     <= 1'b0;
      hf_osc_enable        <= 1'b0;
      mf_osc_enable        <= 1'b0;
      lf_osc_enable        <= 1'b0;
      multiplier_enable    <= 1'b0;
      frequency_tuning     <= TUNE_RST;
      core_reset_n         <= 1'b0;
      core_run             <= 1'b0;
    end else begin
      if (sw == OSCCS_HOLD || (sw == OSCCS_FALL && cur_prev && !cur_level))
        sys_clock_out <= 1'b0;
      else
        sys_clock_out <= cur_level;
      sys_prev <= sys_clock_out;
      if (sys_clock_out && !sys_prev)
        instr_div <= instr_div + 2'h1;
      crystal_in_gpio      <= internal_clock_mode;
      crystal_out_gpio     <= internal_clock_mode && clock_output_enable_n;
      crystal_out_pin_out  <= instr_div[1];
      crystal_out_pin_oe_n <= !(internal_clock_mode
                                && !clock_output_enable_n);
      hf_osc_enable        <= use_hf;
      mf_osc_enable        <= use_mf;
      lf_osc_enable        <= use_lf;
      multiplier_enable    <= mult_on && (scs == 2'h0);
      frequency_tuning     <= frequency_tuning_reg;
      core_reset_n         <= boot != OSCCS_POR && boot != OSCCS_POWER_UP_DELAY_TIMER;
      core_run             <= boot == OSCCS_RUN;
    end
  end
endmodule

// ===== inc/osccs_pkg.sv
package osccs_pkg;
  localparam int        CLK_HZ         = 125_000_000;
  localparam int        POWER_UP_DELAY_TIMER_MS        = 64;
  localparam int        POWER_UP_DELAY_TIMER_CYC       = POWER_UP_DELAY_TIMER_MS * (CLK_HZ / 1000);
  localparam int        OST_EDGES      = 1024;
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_STATUS   = 4'h4;
  localparam logic [3:0] ADDR_TUNE     = 4'h8;
  localparam logic [3:0] ADDR_CFG      = 4'hC;
  localparam int        CTRL_SCS_LSB   = 0;
  localparam int        CTRL_IRCF_LSB  = 3;
  localparam int        CTRL_SWPLL_BIT = 7;
  localparam logic [7:0] CTRL_RST      = 8'h38;
  localparam int        CFG_FOSC_LSB   = 0;
  localparam int        CFG_PLL_BIT    = 3;
  localparam int        CFG_INSTRUCTION_CLOCK_OUT_BIT = 4;
  localparam int        CFG_POWER_UP_DELAY_TIMER_BIT   = 5;
  localparam logic [5:0] CFG_RST       = 6'h3C;
  localparam int        TUNE_W         = 6;
  localparam logic [5:0] TUNE_RST      = 6'h00;
  localparam logic [2:0] FOSC_INT      = 3'h4;
  localparam logic [2:0] FOSC_EC       = 3'h3;
  localparam logic [3:0] IRCF_MULT     = 4'hE;
  localparam int        ST_HF_READY    = 0;
  localparam int        ST_HF_LOCKED   = 1;
  localparam int        ST_HF_STABLE   = 2;
  localparam int        ST_MF_READY    = 3;
  localparam int        ST_LF_READY    = 4;
  localparam int        ST_MULT_READY  = 5;
  localparam int        ST_OST_DONE    = 6;
  localparam int        ST_BUSY        = 7;
  localparam int        ST_PIN         = 8;
  // Clock paths: 0 ext, 1 lf, 2 mf, 3 hf, 4 multiplier
  localparam logic [2:0] SRC_EXT       = 3'h0;
  localparam logic [2:0] SRC_LF        = 3'h1;
  localparam logic [2:0] SRC_MF        = 3'h2;
  localparam logic [2:0] SRC_HF        = 3'h3;
  localparam logic [2:0] SRC_MULT      = 3'h4;
  typedef enum logic [2:0] {
    OSCCS_POR  = 3'b000,
    OSCCS_POWER_UP_DELAY_TIMER = 3'b001,
    OSCCS_OST  = 3'b010,
    OSCCS_RUN  = 3'b011,
    OSCCS_SLP  = 3'b100
  } osccs_boot_t;
  typedef enum logic [2:0] {
    OSCCS_IDLE = 3'b000,
    OSCCS_WAKE = 3'b001,
    OSCCS_FALL = 3'b010,
    OSCCS_HOLD = 3'b011,
    OSCCS_UPD  = 3'b100
  } osccs_sw_t;
endpackage

// ===== tb/osccs_monitor.sv
`timescale 1ns/100ps
module osccs_chk
  import osccs_pkg::*;
#(
  parameter int POWER_UP_DELAY_TIMER_CYCLES = 20
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic        por_supply_ok,
  input wire logic        crystal_in_pin,
  input wire logic        crystal_in_gpio,
  input wire logic        crystal_out_gpio,
  input wire logic        crystal_out_pin_oe_n,
  input wire logic        multiplier_enable,
  input wire logic [5:0]  frequency_tuning,
  input wire logic        core_reset_n,
  input wire logic        core_run
);
  logic [7:0]  sh_ctrl;
  logic [5:0]  sh_cfg;
  logic [5:0]  sh_tune;
  logic [3:0]  quiet;
  logic [15:0] ost_edges;
  logic        xtal_q;
  int          pwr_cyc;
  // Shadow copies let the checker judge outputs without internal state
  wire acc_wr   = avs_write && !avs_waitrequest;
  wire int_mode = (sh_cfg[2:0] == FOSC_INT) || sh_ctrl[1];
  wire exp_mult = (sh_cfg[CFG_PLL_BIT] || sh_ctrl[CTRL_SWPLL_BIT]) &&
                  (sh_ctrl[1:0] == 2'h0);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sh_ctrl <= CTRL_RST;
      sh_cfg  <= CFG_RST;
      sh_tune <= TUNE_RST;
      quiet   <= 4'h0;
    end else if (acc_wr) begin
      quiet <= 4'h0;
      if (avs_address == ADDR_CTRL) sh_ctrl <= avs_writedata[7:0];
      if (avs_address == ADDR_CFG) sh_cfg <= avs_writedata[5:0];
      if (avs_address == ADDR_TUNE) sh_tune <= avs_writedata[5:0];
    end else if (quiet != 4'hF) begin
      quiet <= quiet + 4'h1;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ost_edges <= 16'h0;
      xtal_q    <= 1'b0;
      pwr_cyc   <= 0;
    end else begin
      xtal_q  <= crystal_in_pin;
      pwr_cyc <= por_supply_ok ? pwr_cyc + 1 : 0;
      if (core_run) ost_edges <= 16'h0;
      else if (crystal_in_pin && !xtal_q) ost_edges <= ost_edges + 16'h1;
    end
  end
  AST_WAIT_ONE: assert property (@(posedge clk) disable iff (!rstn)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered after one wait cycle");
  AST_WAIT_PULSE: assert property (@(posedge clk) disable iff (!rstn)
    !avs_waitrequest || !(avs_read || avs_write) |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_MULT_EN: assert property (@(posedge clk) disable iff (!rstn)
    quiet >= 4'h3 |-> multiplier_enable == exp_mult)
    else $error("multiplier enable wrong");
  AST_TUNE: assert property (@(posedge clk) disable iff (!rstn)
    quiet >= 4'h3 |-> frequency_tuning == sh_tune)
    else $error("tuning output differs from register");
  AST_PIN_USE: assert property (@(posedge clk) disable iff (!rstn)
    quiet >= 4'h3 && int_mode |-> crystal_in_gpio &&
    crystal_out_gpio == sh_cfg[4] && crystal_out_pin_oe_n == sh_cfg[4])
    else $error("oscillator pin use wrong in internal mode");
  AST_POR_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    !por_supply_ok [*2] |=> !core_reset_n)
    else $error("core left reset while supply low");
  AST_RUN_OUT_OF_RESET: assert property (@(posedge clk)
    disable iff (!rstn) core_run |-> core_reset_n)
    else $error("core runs during reset");
  AST_OST_COUNT: assert property (@(posedge clk) disable iff (!rstn)
    $rose(core_run) && sh_cfg[2:0] <= 3'h2 && !sh_ctrl[1]
    |-> ost_edges >= 16'd1024)
    else $error("core released before full start-up count");
  AST_POWER_UP_DELAY_TIMER_LEN: assert property (@(posedge clk) disable iff (!rstn)
    $rose(core_reset_n) && !sh_cfg[CFG_POWER_UP_DELAY_TIMER_BIT] |-> pwr_cyc >= POWER_UP_DELAY_TIMER_CYCLES)
    else $error("power-up delay too short");
endmodule

bind osccs_top osccs_chk #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER_CYCLES)) i_osccs_chk (
  .clk                  (clk),
  .rstn                 (rstn),
  .avs_address          (avs_address),
  .avs_read             (avs_read),
  .avs_write            (avs_write),
  .avs_writedata        (avs_writedata),
  .avs_waitrequest      (avs_waitrequest),
  .por_supply_ok        (por_supply_ok),
  .crystal_in_pin       (crystal_in_pin),
  .crystal_in_gpio      (crystal_in_gpio),
  .crystal_out_gpio     (crystal_out_gpio),
  .crystal_out_pin_oe_n (crystal_out_pin_oe_n),
  .multiplier_enable    (multiplier_enable),
  .frequency_tuning     (frequency_tuning),
  .core_reset_n         (core_reset_n),
  .core_run             (core_run)
);

// ===== tb/osccs_osc_model.sv
`timescale 1ns/100ps
module osccs_osc_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hf_en,
  input wire logic mf_en,
  input wire logic lf_en,
  input wire logic mult_en,
  output logic     xtal,
  output logic     hf,
  output logic     mf,
  output logic     lf,
  output logic     mult
);
  logic [3:0] div;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) div <= 4'h0;
    else div <= div + 4'h1;
  end
  // Crystal runs free; a disabled oscillator stands low, as a stopped one
  assign xtal = div[1];
  assign hf   = hf_en & div[1];
  assign mf   = mf_en & div[2];
  assign lf   = lf_en & div[3];
  assign mult = mult_en & div[0];
endmodule

// ===== tb/tb_oscillator_clock_select.sv
`timescale 1ns/100ps
module tb_oscillator_clock_select
  import osccs_pkg::*;
;
  localparam int POWER_UP_DELAY_TIMER_T = 20;
  logic        clk, rstn, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, r;
  logic        por_supply_ok, sleep_req, wake_req, xq;
  logic        xtal, hf, mf, lf, mult, pin_out, pin_oe_n, in_gpio, out_gpio;
  logic        hf_en, mf_en, lf_en, mult_en, core_reset_n, core_run, sclk;
  logic [5:0]  tune, cf;
  logic [7:0]  ct;
  int          failures, cmp_count, cyc, seed, n, e;
  // Released pin floats high through its pull-up
  wire         pin_lvl = pin_oe_n ? 1'b1 : pin_out;
  always #4 clk = ~clk;
  osccs_top #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER_T)) i_osccs_top (
    .clk(clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .por_supply_ok(por_supply_ok),
    .sleep_req(sleep_req), .wake_req(wake_req), .crystal_in_pin(xtal),
    .high_freq_internal_clock(hf), .mid_freq_internal_clock(mf),
    .low_freq_internal_clock(lf), .internal_multiplier(mult),
    .crystal_out_pin_in(pin_lvl), .crystal_out_pin_out(pin_out),
    .crystal_out_pin_oe_n(pin_oe_n), .crystal_in_gpio(in_gpio),
    .crystal_out_gpio(out_gpio), .hf_osc_enable(hf_en),
    .mf_osc_enable(mf_en), .lf_osc_enable(lf_en),
    .multiplier_enable(mult_en), .frequency_tuning(tune),
    .core_reset_n(core_reset_n), .core_run(core_run),
    .sys_clock_out(sclk));
  osccs_osc_model i_osccs_osc_model (.clk(clk), .rstn(rstn), .hf_en(hf_en),
    .mf_en(mf_en), .lf_en(lf_en), .mult_en(mult_en), .xtal(xtal), .hf(hf),
    .mf(mf), .lf(lf), .mult(mult));
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic wait_bit(input int b, input logic v);
    n = 0;
    do begin
      bus(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (rd[b] !== v && n < 300);
  endtask
  task automatic wait_sig(input logic v, ref logic s);
    n = 0;
    while (s !== v && n < 8000) begin
      @(posedge clk);
      n++;
    end
  endtask
  function automatic logic exp_mult(input logic [5:0] c, input logic [7:0] t);
    return (c[CFG_PLL_BIT] | t[CTRL_SWPLL_BIT]) & (t[1:0] == 2'h0);
  endfunction
  // Hang guard well above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    {clk, rstn, avs_read, avs_write, por_supply_ok, sleep_req} = 6'h0;
    {avs_address, avs_writedata, wake_req} = 37'h0;
    failures  = 0;
    cmp_count = 0;
    cyc       = 0;
    seed = 32'h9A9B;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    chk("core_reset_n", 32'h0, core_reset_n);
    por_supply_ok <= 1'b1;
    wait_sig(1'b1, core_run);
    chk("core_run", 32'h1, core_run);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h38, rd);
    bus(1'b0, ADDR_CFG, 32'h0);
    chk("cfg", 32'h3C, rd);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("in_gpio", 32'h1, in_gpio);
    wait_bit(ST_MF_READY, 1'b1);
    chk("mf_ready", 32'h1, rd[ST_MF_READY]);
    bus(1'b1, ADDR_CTRL, 32'h78);
    wait_bit(ST_HF_READY, 1'b1);
    chk("hf_ready", 32'h1, rd[ST_HF_READY]);
    wait_bit(ST_BUSY, 1'b0);
    chk("busy", 32'h0, rd[ST_BUSY]);
    repeat (600) @(posedge clk);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("locked_stable", 32'h3, rd[2:1]);
    chk("pin_level", 32'h1, rd[ST_PIN]);
    bus(1'b1, ADDR_CTRL, 32'h68);
    wait_bit(ST_BUSY, 1'b0);
    chk("same_src_fast", 32'h1, n < 16);
    // Divide by four of the high clock gives one rise per 16 cycles
    e  = 0;
    xq = sclk;
    repeat (160) begin
      @(posedge clk);
      if (sclk && !xq) e++;
      xq = sclk;
    end
    chk("sclk_rises", 32'h1, e >= 9 && e <= 11);
    for (int i = 0; i < 14; i++) begin
      r = $random(seed);
      {cf, ct} = {1'b1, r[4:3], 3'h4, r[7:0]};
      if (i == 0) {cf, ct} = 14'h34F0;
      if (i == 1) {cf, ct} = 14'h3C02;
      if (i == 2) {cf, ct} = 14'h3C38;
      bus(1'b1, ADDR_CFG, {26'h0, cf});
      bus(1'b1, ADDR_CTRL, {24'h0, ct});
      bus(1'b1, ADDR_TUNE, {26'h0, r[13:8]});
      bus(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl_back", {24'h0, ct}, rd);
      repeat (3) @(posedge clk);
      chk("mult_en", exp_mult(cf, ct), mult_en);
      chk("tuning", r[13:8], tune);
      chk("out_gpio", cf[4], out_gpio);
      chk("pin_oe_n", cf[4], pin_oe_n);
    end
    bus(1'b1, ADDR_CFG, 32'h1C);
    por_supply_ok <= 1'b0;
    repeat (4) @(posedge clk);
    chk("por_hold", 32'h0, core_reset_n);
    por_supply_ok <= 1'b1;
    wait_sig(1'b1, core_reset_n);
    chk("power_up_delay_timer_len", 32'h1, n >= POWER_UP_DELAY_TIMER_T && n <= POWER_UP_DELAY_TIMER_T + 8);
    wait_sig(1'b1, core_run);
    bus(1'b1, ADDR_CFG, 32'h30);
    bus(1'b1, ADDR_CTRL, 32'h38);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    wait_sig(1'b0, core_run);
    chk("asleep", 32'h0, core_run);
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    e  = 0;
    n  = 0;
    xq = xtal;
    while (core_run !== 1'b1 && n < 8000) begin
      @(posedge clk);
      if (xtal && !xq) e++;
      xq = xtal;
      n++;
    end
    chk("ost_edges", 32'h1, e >= 1024 && e <= 1030);
    final_report();
  end
endmodule
